// >>> hdl/pogat_defines.vh
`ifndef POGAT_DEFINES_VH
`define POGAT_DEFINES_VH

// Register indices; byte address is four times the index
`define POGAT_IDX_CTRL 12'hF20
`define POGAT_IDX_MASK 12'hF27
`define POGAT_IDX_TRIG 12'hF29
`define POGAT_IDX_OFF 12'hF2A
`define POGAT_IDX_STAT 12'hF2B

// Reset values
`define POGAT_RST_CTRL 2'h0
`define POGAT_RST_MASK 6'h00
`define POGAT_RST_TRIG 8'h00
`define POGAT_RST_OFF 6'h00

// Main modulator control fields
`define POGAT_CTRL_MASK_EN 0
`define POGAT_CTRL_SW_RECOVER 1

// Trigger configuration fields
`define POGAT_TRIG_POL 7
`define POGAT_TRIG_HEN 6
`define POGAT_TRIG_HIGH_INACTIVE_GROUP_ENABLE 5
`define POGAT_TRIG_LEN 4
`define POGAT_TRIG_LOW_INACTIVE_GROUP_ENABLE 3
`define POGAT_TRIG_SEL_HI 2
`define POGAT_TRIG_SEL_LO 0

// Status fields
`define POGAT_STAT_FAULT_FLAG 0
`define POGAT_STAT_FAULT_ACTIVE 1
`define POGAT_STAT_MATCH 2
`define POGAT_STAT_FAULT_IN 3

// Low-side-inactive group: 1 uses negated low outputs, 0 the negated high ones
`define POGAT_LOW_INACTIVE_GROUP_ENABLE_USE_LOW 1'h1

`endif

// >>> hdl/pogat_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pogat_defines.vh"

// Function
// - Per-output mask acts only when output_mask_enable in main control is set.
// - Low-side mask bit 0 passes modulator; 1 forces low-side off state.
// - High-side mask bit 0 passes modulator; 1 forces high-side off state.
// - Masking never alters the modulator; only masked pins stop following it.
// - A fault forces all six outputs to their off states regardless of mask.
// - Match is polarity XOR the OR of four enabled product groups.
// - Low-inactive group uses negated low outputs here; selectable in the header.
// - A group takes part in the OR only while its enable bit is set.
// - Cleared channel select makes its term true; set uses the output level.
// - Polarity 0 matches while an enabled group holds; polarity 1 while none does.
// - One conversion starts on each rising edge of the match signal.
// - Trigger configuration never influences the driven output levels.
// - Software recovery needs fault gone, flag cleared and a reload.
module pogat_top (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [13:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [2:0] mod_high,
    input wire [2:0] mod_low,
    input wire fault_in,
    input wire period_start,
    input wire reload,
    output wire [2:0] pwm_high,
    output wire [2:0] pwm_low,
    output wire conversion_match,
    output wire adc_start
);

    localparam ST_ADDR = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0] bus_state_ff;
    reg [1:0] nxt_bus_state;
    reg [7:0] readdata_ff;
    reg [7:0] nxt_readdata;
    reg waitrequest_ff;
    reg nxt_waitrequest;

    reg [1:0] ctrl_ff;
    reg [1:0] nxt_ctrl;
    reg [5:0] mask_ff;
    reg [5:0] nxt_mask;
    reg [7:0] trig_ff;
    reg [7:0] nxt_trig;
    reg [5:0] off_ff;
    reg [5:0] nxt_off;

    reg fault_flag_ff;
    reg nxt_fault_flag;
    reg fault_active_ff;
    reg nxt_fault_active;

    reg [2:0] pwm_high_ff;
    reg [2:0] pwm_low_ff;
    reg [2:0] nxt_pwm_high;
    reg [2:0] nxt_pwm_low;
    reg match_ff;
    reg nxt_match;
    reg adc_start_ff;
    reg nxt_adc_start;

    wire [11:0] reg_index;
    wire wr_lane0;
    wire bus_fire;
    wire flag_clear;

    wire [2:0] term_hi;
    wire [2:0] term_lo;
    wire [2:0] term_nhi;
    wire [2:0] term_nlo;
    wire grp_hi;
    wire grp_lo;
    wire grp_nhi;
    wire grp_nlo;
    wire grp_or;

    assign reg_index = avs_address[13:2];
    assign wr_lane0 = avs_write & avs_byteenable[0];
    // Writes land only on the edge that the master sees waitrequest low
    assign bus_fire = (bus_state_ff == ST_DONE) & (avs_read | avs_write);
    assign flag_clear = bus_fire & wr_lane0 & (reg_index == `POGAT_IDX_STAT) &
                        avs_writedata[`POGAT_STAT_FAULT_FLAG];

    // Bus handshake: one wait state, read data captured before release
    always @* begin
        nxt_bus_state = bus_state_ff;
        nxt_waitrequest = waitrequest_ff;
        nxt_readdata = readdata_ff;
        case (bus_state_ff)
            ST_ADDR: begin
                if (avs_read | avs_write) begin
                    nxt_bus_state = ST_DONE;
                    nxt_waitrequest = 1'b0;
                    if (!avs_read) begin
                        nxt_readdata = 8'h00;
                    end else if (reg_index == `POGAT_IDX_CTRL) begin
                        nxt_readdata = {6'h00, ctrl_ff};
                    end else if (reg_index == `POGAT_IDX_MASK) begin
                        nxt_readdata = {2'h0, mask_ff};
                    end else if (reg_index == `POGAT_IDX_TRIG) begin
                        nxt_readdata = trig_ff;
                    end else if (reg_index == `POGAT_IDX_OFF) begin
                        nxt_readdata = {2'h0, off_ff};
                    end else if (reg_index == `POGAT_IDX_STAT) begin
                        nxt_readdata = {4'h0, fault_in, match_ff, fault_active_ff, fault_flag_ff};
                    end else begin
                        nxt_readdata = 8'h00;
                    end
                end
            end
            ST_DONE: begin
                nxt_bus_state = ST_ADDR;
                nxt_waitrequest = 1'b1;
            end
            default: begin
                nxt_bus_state = ST_ADDR;
                nxt_waitrequest = 1'b1;
            end
        endcase
    end

    // Register writes; unmapped addresses are ignored
    always @* begin
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        nxt_trig = trig_ff;
        nxt_off = off_ff;
        if (bus_fire & wr_lane0) begin
            if (reg_index == `POGAT_IDX_CTRL) begin
                nxt_ctrl = avs_writedata[1:0];
            end else if (reg_index == `POGAT_IDX_MASK) begin
                nxt_mask = avs_writedata[5:0];
            end else if (reg_index == `POGAT_IDX_TRIG) begin
                nxt_trig = avs_writedata[7:0];
            end else if (reg_index == `POGAT_IDX_OFF) begin
                nxt_off = avs_writedata[5:0];
            end
        end
    end

    // Fault flag is sticky; a fault in the clear cycle keeps it set
    always @* begin
        nxt_fault_flag = fault_flag_ff;
        if (flag_clear) begin
            nxt_fault_flag = 1'b0;
        end
        if (fault_in) begin
            nxt_fault_flag = 1'b1;
        end
    end

    // Fault hold and recovery
    always @* begin
        nxt_fault_active = fault_active_ff;
        if (fault_in) begin
            nxt_fault_active = 1'b1;
        end else if (fault_active_ff) begin
            if (ctrl_ff[`POGAT_CTRL_SW_RECOVER]) begin
                // Flag must already read clear; a clear in this cycle waits for the next reload
                if (!fault_flag_ff & reload) begin
                    nxt_fault_active = 1'b0;
                end
            end else if (period_start) begin
                nxt_fault_active = 1'b0;
            end
        end
    end

    // Output gating; the modulator inputs are only read, never fed back
    always @* begin
        nxt_pwm_high = mod_high;
        nxt_pwm_low = mod_low;
        if (nxt_fault_active) begin
            nxt_pwm_high = {off_ff[4], off_ff[2], off_ff[0]};
            nxt_pwm_low = {off_ff[5], off_ff[3], off_ff[1]};
        end else if (ctrl_ff[`POGAT_CTRL_MASK_EN]) begin
            if (mask_ff[0]) begin
                nxt_pwm_high[0] = off_ff[0];
            end
            if (mask_ff[2]) begin
                nxt_pwm_high[1] = off_ff[2];
            end
            if (mask_ff[4]) begin
                nxt_pwm_high[2] = off_ff[4];
            end
            if (mask_ff[1]) begin
                nxt_pwm_low[0] = off_ff[1];
            end
            if (mask_ff[3]) begin
                nxt_pwm_low[1] = off_ff[3];
            end
            if (mask_ff[5]) begin
                nxt_pwm_low[2] = off_ff[5];
            end
        end
    end

    // Trigger terms watch the driven pins, so masked or faulted levels count
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_term
            assign term_hi[ch] = ~trig_ff[ch] | pwm_high_ff[ch];
            assign term_lo[ch] = ~trig_ff[ch] | pwm_low_ff[ch];
            assign term_nhi[ch] = ~trig_ff[ch] | ~pwm_high_ff[ch];
            assign term_nlo[ch] = ~trig_ff[ch] |
                                  ~(`POGAT_LOW_INACTIVE_GROUP_ENABLE_USE_LOW ? pwm_low_ff[ch] : pwm_high_ff[ch]);
        end
    endgenerate

    assign grp_hi = trig_ff[`POGAT_TRIG_HEN] & (&term_hi);
    assign grp_lo = trig_ff[`POGAT_TRIG_LEN] & (&term_lo);
    assign grp_nhi = trig_ff[`POGAT_TRIG_HIGH_INACTIVE_GROUP_ENABLE] & (&term_nhi);
    assign grp_nlo = trig_ff[`POGAT_TRIG_LOW_INACTIVE_GROUP_ENABLE] & (&term_nlo);
    assign grp_or = grp_hi | grp_lo | grp_nhi | grp_nlo;

    always @* begin
        nxt_match = trig_ff[`POGAT_TRIG_POL] ^ grp_or;
        nxt_adc_start = nxt_match & ~match_ff;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_ff <= ST_ADDR;
            waitrequest_ff <= 1'b1;
            readdata_ff <= 8'h00;
            ctrl_ff <= `POGAT_RST_CTRL;
            mask_ff <= `POGAT_RST_MASK;
            trig_ff <= `POGAT_RST_TRIG;
            off_ff <= `POGAT_RST_OFF;
            fault_flag_ff <= 1'b0;
            fault_active_ff <= 1'b0;
            pwm_high_ff <= 3'h0;
            pwm_low_ff <= 3'h0;
            match_ff <= 1'b0;
            adc_start_ff <= 1'b0;
        end else if (clk_en) begin
            bus_state_ff <= nxt_bus_state;
            waitrequest_ff <= nxt_waitrequest;
            readdata_ff <= nxt_readdata;
            ctrl_ff <= nxt_ctrl;
            mask_ff <= nxt_mask;
            trig_ff <= nxt_trig;
            off_ff <= nxt_off;
            fault_flag_ff <= nxt_fault_flag;
            fault_active_ff <= nxt_fault_active;
            pwm_high_ff <= nxt_pwm_high;
            pwm_low_ff <= nxt_pwm_low;
            match_ff <= nxt_match;
            adc_start_ff <= nxt_adc_start;
        end
    end

    assign avs_readdata = {24'h000000, readdata_ff};
    assign avs_waitrequest = waitrequest_ff;
    assign pwm_high = pwm_high_ff;
    assign pwm_low = pwm_low_ff;
    assign conversion_match = match_ff;
    assign adc_start = adc_start_ff;

endmodule

`default_nettype wire

// >>> test/pogat_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pogat_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic avs_waitrequest,
    input wire logic [2:0] mod_high,
    input wire logic [2:0] mod_low,
    input wire logic fault_in,
    input wire logic period_start,
    input wire logic reload,
    input wire logic [2:0] pwm_high,
    input wire logic [2:0] pwm_low,
    input wire logic conversion_match,
    input wire logic adc_start
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_start_on_rise: assert property ($rose(conversion_match) |-> adc_start)
        else $error("match rose without start");
    a_start_needs_rise: assert property (adc_start |-> $rose(conversion_match))
        else $error("start without match edge");
    a_start_one_cycle: assert property (adc_start |=> !adc_start)
        else $error("start pulse too long");
    a_fault_all_off: assert property (fault_in |=> pwm_high == 3'h0 && pwm_low == 3'h0)
        else $error("fault left a pin on");
    // A pin may only be high if the modulator drove it high one edge before
    a_high_from_mod: assert property ((pwm_high & ~$past(mod_high)) == 3'h0)
        else $error("high pin not from modulator");
    a_low_from_mod: assert property ((pwm_low & ~$past(mod_low)) == 3'h0)
        else $error("low pin not from modulator");
    a_hold_after_fault: assert property ($fell(fault_in) && !period_start && !reload
        |=> pwm_high == 3'h0 && pwm_low == 3'h0)
        else $error("outputs resumed without recovery event");
    a_match_has_cause: assert property ($changed(conversion_match) |-> !$past(avs_waitrequest, 2)
        || $past({pwm_high, pwm_low}) != $past({pwm_high, pwm_low}, 2))
        else $error("match moved without cause");
    cover property (adc_start);
    cover property ($fell(fault_in));
    cover property (fault_in ##1 pwm_low == 3'h0);
endmodule
`default_nettype wire

// >>> test/pogat_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pogat_far_side (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic adc_start,
    output logic [7:0] conv_cnt_ff
);
    // Converter side: each start pulse is one conversion
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt_ff <= 8'h00;
        end else if (adc_start === 1'b1) begin
            conv_cnt_ff <= conv_cnt_ff + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [13:0] avs_address = 14'h0000;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [2:0] mod_high = 3'h7, mod_low = 3'h7, ev = 3'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, conversion_match, adc_start;
    wire [2:0] pwm_high, pwm_low;
    wire [7:0] conv_cnt_ff;
    int miscompares = 0, num_checks = 0, exp_rises = 0;
    logic [7:0] rdat;
    // Each row: expected match, config, high pins, low pins
    logic [14:0] rows [9] = '{15'h51F8, 15'h11D8, 15'h50D8, 15'h31F8, 15'h45C7,
        15'h49C7, 15'h43F8, 15'h01FF, 15'h61EA};
    always #25 sys_clk = ~sys_clk;
    pogat_top dut_u (.sys_clk, .rst_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .mod_high,
        .mod_low, .fault_in(ev[2]), .period_start(ev[1]), .reload(ev[0]), .pwm_high,
        .pwm_low, .conversion_match, .adc_start);
    pogat_far_side far_u (.sys_clk, .rst_n, .adc_start, .conv_cnt_ff);
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_read <= !wr;
        avs_write <= wr;
        // Waitrequest is a flop that flips on the very edge it is judged at, so look mid-cycle
        do begin
            @(negedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        @(posedge sys_clk);
        if (n == 20) miscompares++;
        rdat = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic pulse(input logic [2:0] v);
        ev <= v;
        @(posedge sys_clk);
        ev <= 3'h0;
        cyc(3);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        cyc(4000);
        miscompares++;
        complete_run();
    end
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        bus(0, 12'hF27, 8'h00);
        `CHK(rdat, 8'h00)
        bus(0, 12'hF29, 8'h00);
        `CHK(rdat, 8'h00)
        bus(1, 12'h100, 8'hA5);
        bus(0, 12'h100, 8'h00);
        `CHK(rdat, 8'h00)
        bus(1, 12'hF27, 8'hFF);
        bus(0, 12'hF27, 8'h00);
        `CHK(rdat, 8'h3F)
        bus(1, 12'hF20, 8'h01);
        for (int i = 0; i < 6; i++) begin
            bus(1, 12'hF27, 8'h01 << i);
            cyc(1);
            `CHK(pwm_high, ~{i == 4, i == 2, i == 0})
            `CHK(pwm_low, ~{i == 5, i == 3, i == 1})
        end
        bus(1, 12'hF20, 8'h00);
        cyc(1);
        `CHK({pwm_high, pwm_low}, 6'h3F)
        pulse(3'h4);
        `CHK({pwm_high, pwm_low}, 6'h00)
        pulse(3'h2);
        `CHK({pwm_high, pwm_low}, 6'h3F)
        // Software recovery: period start alone must not release the pins
        bus(1, 12'hF20, 8'h02);
        pulse(3'h4);
        pulse(3'h2);
        `CHK({pwm_high, pwm_low}, 6'h00)
        bus(0, 12'hF2B, 8'h00);
        `CHK(rdat[0], 1'b1)
        bus(1, 12'hF2B, 8'h01);
        pulse(3'h1);
        `CHK({pwm_high, pwm_low}, 6'h3F)
        bus(1, 12'hF20, 8'h00);
        // Clear the config first so every row starts from a low match
        foreach (rows[k]) begin
            bus(1, 12'hF29, 8'h00);
            mod_high <= rows[k][5:3];
            mod_low <= rows[k][2:0];
            cyc(2);
            bus(1, 12'hF29, rows[k][13:6]);
            cyc(2);
            `CHK(conversion_match, rows[k][14])
            `CHK({pwm_high, pwm_low}, rows[k][5:0])
            exp_rises += rows[k][14];
        end
        `CHK(conv_cnt_ff, exp_rises[7:0])
        complete_run();
    end
endmodule
bind pogat_top pogat_chk chk_u (.sys_clk, .rst_n, .avs_waitrequest, .mod_high, .mod_low, .fault_in,
    .period_start, .reload, .pwm_high, .pwm_low, .conversion_match, .adc_start);
`default_nettype wire
